// *** logic/smt_device.sv ***
// Purpose: serial engine, slave transmitter and buffered master transmitter
// Assumes: pins synchronous to mclk_i; open-drain via output enables
// Notes:   receiver modes and general-call receive are not built
//
// Overview of operation
// - Own address read acked: flag, A8h
// - Lost arbitration then read-addressed: B0h
// - Slave byte acked: B8h, wait host
// - Ack enable at load picks last byte
// - C0h/C8h with AA 0: not addressed
// - C0h/C8h with AA 1: address again
// - Start request sends START when bus free
// - Host answers slave with mode 0
// - Host initialises control for buffered send
// - Wait oscillator start after enable
// - AA 0 never acks own address
// - Start request: START then 08h
// - Host loads count bytes, address byte included
// - Byte count in bits 6..0
// - Last-byte bit ignored when sending
// - Control write clears flag, interrupt
// - Address acked, count one: 18h
// - Address not acked: 20h
// - All bytes acked: 28h
// - Data byte not acked: 30h
// - Arbitration lost sending: 38h
// - Not addressed: bus left released
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module smt_device
	import smt_pkg::*;
#(
	parameter int         OSC_CYC  = OSC_START_CYC,
	parameter int         QTR_CYC  = BUS_QTR_CYC,
	parameter int         DEPTH    = BUF_DEPTH,
	parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEF
)(
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic arst_n_i,
	// Parallel bus
	smt_pbus_if.dev   pb,
	// Serial clock pin
	input  wire logic scl_i,
	output logic      scl_o,
	output logic      scl_oe_o,
	// Serial data pin
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o
);
	localparam int OW = $clog2(OSC_CYC + 1);
	localparam int PW = $clog2(DEPTH);

	logic [7:0]    ctl_q, cnt_q, stat_q;
	logic          si_q;
	logic [OW-1:0] osc_q;
	logic [7:0]    buf_q [DEPTH];
	logic [PW-1:0] wptr_q, mptr_q;
	logic          scl_q, sda_q, busy_q;
	smt_mst_t      m_q;
	logic [1:0]    ph_q;
	logic [3:0]    mbit_q;
	logic [7:0]    msh_q, m_code_q;
	logic          m_scl_low_q, m_sda_low_q, m_ev_q, nack_q, lost_addr_q;
	smt_slv_t      s_q;
	logic [3:0]    sbit_q;
	logic [7:0]    ssh_q, s_code_q;
	logic          s_scl_low_q, s_sda_low_q, s_ev_q, saa_q, snack_q;
	logic          slost_q;

	////////////////////////////////////////////////////////////////////////
	// Decode
	wire logic       wr_ctl, wr_dat, wr_cnt, act, ready, tick;
	wire logic       scl_rise, scl_fall, start_det, stop_det;
	wire logic       free_start, addr_done, stop_done, last, ev, si_d;
	wire logic [7:0] ev_code, rd_val;
	wire logic [PW-1:0] mnext;
	assign wr_ctl = pb.wr && (pb.addr == REG_CONTROL);
	assign wr_dat = pb.wr && (pb.addr == REG_DATA);
	assign wr_cnt = pb.wr && (pb.addr == REG_COUNT);
	assign ready = (osc_q == OW'(OSC_CYC));
	assign act   = ctl_q[CTL_EN] && ready;
	assign scl_rise  = scl_i && !scl_q;
	assign scl_fall  = !scl_i && scl_q;
	assign start_det = scl_i && scl_q && sda_q && !sda_i;
	assign stop_det  = scl_i && scl_q && !sda_q && sda_i;
	assign free_start = act && ctl_q[CTL_STA] && !busy_q && !si_q;
	assign addr_done  = (s_q == S_ADDR) && scl_rise && (sbit_q == 4'h7);
	assign stop_done  = (m_q == M_STOP) && tick && (ph_q == 2'h3);
	assign mnext = mptr_q + 1'b1;
	// count from low seven bits; last-byte bit unused
	assign last = ({1'b0, mnext} >= cnt_q[CNT_BC_W-1:0]);
	assign ev      = m_ev_q || s_ev_q;
	assign ev_code = m_ev_q ? m_code_q : s_code_q;
	// control write clears flag; event wins over the clear
	assign si_d = ev || (si_q && !wr_ctl);
	assign rd_val = (pb.addr == REG_STATUS) ? stat_q :
		(pb.addr == REG_DATA) ? buf_q[0] :
		(pb.addr == REG_COUNT) ? cnt_q :
		{ctl_q[7:4], si_q, ctl_q[2:0]};
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	smt_tick #(
		.DIV      (QTR_CYC)
	) smt_tick_inst (
		.mclk_i   (mclk_i),
		.arst_n_i (arst_n_i),
		.en_i     ((m_q != M_IDLE) && (m_q != M_HOLD)),
		.tick_o   (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Registers, flag and interrupt
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ctl_q    <= CTL_RST;
			cnt_q    <= CNT_RST;
			stat_q   <= ST_IDLE;
			si_q     <= 1'b0;
			pb.int_n <= 1'b1;
			pb.rdata <= 8'h00;
			osc_q    <= '0;
			wptr_q   <= '0;
		end
		else
		begin
			if (wr_ctl)
				ctl_q <= pb.wdata & CTL_WMASK;
			else if (stop_done)
				ctl_q[CTL_STO] <= 1'b0;
			if (wr_cnt)
				cnt_q <= pb.wdata;
			// status changes only on an event
			if (ev)
				stat_q <= ev_code;
			si_q     <= si_d;
			pb.int_n <= !si_d;
			if (pb.rd)
				pb.rdata <= rd_val;
			osc_q <= !ctl_q[CTL_EN] ? '0 : (ready ? osc_q : osc_q + 1'b1);
			if (ev)
				wptr_q <= '0;
			else if (wr_dat && ctl_q[CTL_MODE] && wptr_q < PW'(DEPTH - 1))
				wptr_q <= wptr_q + 1'b1;
		end
	end

	// Buffer holds no reset; contents are valid only once loaded
	always_ff @(posedge mclk_i)
	begin
		if (wr_dat)
			buf_q[wptr_q] <= pb.wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin sampling and drive
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			busy_q   <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end
		else
		begin
			scl_q    <= scl_i;
			sda_q    <= sda_i;
			busy_q   <= act && (start_det || (busy_q && !stop_det));
			scl_oe_o <= m_scl_low_q || s_scl_low_q;
			sda_oe_o <= m_sda_low_q || s_sda_low_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Buffered master transmitter, four ticks per bit
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			m_q <= M_IDLE;
			{ph_q, mbit_q, mptr_q, msh_q, m_code_q} <= '0;
			{m_scl_low_q, m_sda_low_q, m_ev_q, nack_q, lost_addr_q} <= '0;
		end
		else
		begin
			m_ev_q <= 1'b0;
			if (addr_done)
				lost_addr_q <= 1'b0;
			if (!act)
			begin
				m_q         <= M_IDLE;
				m_scl_low_q <= 1'b0;
				m_sda_low_q <= 1'b0;
			end
			else
			case (m_q)
			M_IDLE:
				if (free_start)
				begin
					m_q  <= M_START;
					ph_q <= 2'h0;
				end
			M_START:
				if (tick)
				case (ph_q)
				2'h0: {m_sda_low_q, ph_q} <= {1'b0, 2'h1};
				2'h1: {m_scl_low_q, ph_q} <= {1'b0, 2'h2};
				2'h2:
					if (scl_i && sda_i)
						{m_sda_low_q, ph_q} <= {1'b1, 2'h3};
				default:
				begin
					m_scl_low_q <= 1'b1;
					m_ev_q      <= 1'b1;
					m_code_q    <= ST_START;
					m_q         <= M_HOLD;
					ph_q        <= 2'h0;
				end
				endcase
			M_HOLD:
				if (wr_ctl)
				begin
					ph_q <= 2'h0;
					if (pb.wdata[CTL_STO])
						m_q <= M_STOP;
					else if (pb.wdata[CTL_STA] && stat_q != ST_START)
						m_q <= M_START;
					else
					begin
						m_q    <= M_BIT;
						mptr_q <= '0;
						mbit_q <= 4'h0;
						msh_q  <= buf_q[0];
					end
				end
			M_BIT:
				if (tick)
				case (ph_q)
				2'h0:
				begin
					m_sda_low_q <= (mbit_q == 4'h8) ? 1'b0 : !msh_q[7];
					ph_q        <= 2'h1;
				end
				2'h1: {m_scl_low_q, ph_q} <= {1'b0, 2'h2};
				2'h2:
					if (scl_i)
					begin
						ph_q   <= 2'h3;
						nack_q <= sda_i;
						if (mbit_q != 4'h8 && !m_sda_low_q && !sda_i)
						begin
							m_q         <= M_IDLE;
							m_sda_low_q <= 1'b0;
							lost_addr_q <= (mptr_q == '0);
							m_ev_q      <= (mptr_q != '0);
							m_code_q    <= ST_LOST;
						end
					end
				default:
				begin
					m_scl_low_q <= 1'b1;
					ph_q        <= 2'h0;
					if (mbit_q != 4'h8)
					begin
						mbit_q <= mbit_q + 1'b1;
						msh_q  <= {msh_q[6:0], 1'b0};
					end
					else if (nack_q || last)
					begin
						m_q         <= M_HOLD;
						m_sda_low_q <= 1'b1;
						m_ev_q      <= 1'b1;
						if (nack_q)
							m_code_q <= (mptr_q == '0) ? ST_A_NACK : ST_D_NACK;
						else
							m_code_q <= (mptr_q == '0) ? ST_A_ACK : ST_D_ACK;
					end
					else
					begin
						mbit_q <= 4'h0;
						mptr_q <= mnext;
						msh_q  <= buf_q[mnext];
					end
				end
				endcase
			M_STOP:
				if (tick)
				case (ph_q)
				2'h0: {m_sda_low_q, ph_q} <= {1'b1, 2'h1};
				2'h1: {m_scl_low_q, ph_q} <= {1'b0, 2'h2};
				2'h2:
					if (scl_i)
						{m_sda_low_q, ph_q} <= {1'b0, 2'h3};
				default: m_q <= M_IDLE;
				endcase
			default: m_q <= M_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slave transmitter, driven by bus edges
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s_q <= S_IDLE;
			{sbit_q, ssh_q, s_code_q} <= '0;
			{s_scl_low_q, s_sda_low_q, s_ev_q, saa_q, snack_q, slost_q} <= '0;
		end
		else
		begin
			s_ev_q <= 1'b0;
			if (!act || stop_det || start_det)
			begin
				s_q         <= (act && start_det) ? S_ADDR : S_IDLE;
				sbit_q      <= 4'h0;
				s_scl_low_q <= 1'b0;
				s_sda_low_q <= 1'b0;
			end
			else
			case (s_q)
			S_ADDR:
				if (scl_rise)
				begin
					ssh_q  <= {ssh_q[6:0], sda_i};
					sbit_q <= sbit_q + 1'b1;
					if (sbit_q == 4'h7)
					begin
						slost_q <= lost_addr_q;
						sbit_q  <= 4'h0;
						if (ssh_q[6:0] == OWN_ADDR && sda_i &&
							ctl_q[CTL_AA] && m_q != M_BIT)
							s_q <= S_ACK;
						else
						begin
							s_q      <= S_DONE;
							s_ev_q   <= lost_addr_q;
							s_code_q <= ST_LOST;
						end
					end
				end
			S_ACK:
				if (scl_fall)
				begin
					s_sda_low_q <= (sbit_q == 4'h0);
					sbit_q      <= 4'h1;
					if (sbit_q != 4'h0)
					begin
						s_scl_low_q <= 1'b1;
						s_ev_q      <= 1'b1;
						s_code_q    <= slost_q ? ST_LOST_SLA : ST_SLA_R;
						s_q         <= S_WAIT;
					end
				end
			S_WAIT:
				if (wr_ctl)
				begin
					saa_q       <= pb.wdata[CTL_AA];
					ssh_q       <= buf_q[0];
					s_sda_low_q <= !buf_q[0][7];
					s_scl_low_q <= 1'b0;
					sbit_q      <= 4'h0;
					s_q         <= S_TX;
				end
			S_TX:
				if (scl_fall)
				begin
					sbit_q      <= sbit_q + 1'b1;
					ssh_q       <= {ssh_q[6:0], 1'b0};
					s_sda_low_q <= (sbit_q == 4'h7) ? 1'b0 : !ssh_q[6];
					if (sbit_q == 4'h7)
						s_q <= S_RACK;
				end
			S_RACK:
				if (scl_rise)
					snack_q <= sda_i;
				else if (scl_fall)
				begin
					s_ev_q <= 1'b1;
					if (!snack_q && saa_q)
					begin
						s_code_q    <= ST_S_ACK;
						s_scl_low_q <= 1'b1;
						s_q         <= S_WAIT;
					end
					else
					begin
						s_code_q <= snack_q ? ST_S_NACK : ST_S_LAST;
						s_q      <= S_DONE;
					end
				end
			S_IDLE, S_DONE: s_q <= s_q;
			default: s_q <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** logic/smt_pkg.sv ***
// Purpose: shared constants and types of the serial engine and its host
// Assumes: 200 MHz single clock
// Notes:   parallel-bus indices double as host word offsets
`default_nettype none
package smt_pkg;
	// Timing
	localparam int CLK_NS        = 5;
	localparam int OSC_START_NS  = 550000;
	localparam int OSC_START_CYC = (OSC_START_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUS_QTR_NS    = 625;
	localparam int BUS_QTR_CYC   = (BUS_QTR_NS + CLK_NS - 1) / CLK_NS;
	// Buffer and own address
	localparam int         BUF_DEPTH    = 68;
	localparam logic [6:0] OWN_ADDR_DEF = 7'h2A;
	// Parallel-bus register indices
	localparam logic [1:0] REG_STATUS  = 2'h0;
	localparam logic [1:0] REG_DATA    = 2'h1;
	localparam logic [1:0] REG_COUNT   = 2'h2;
	localparam logic [1:0] REG_CONTROL = 2'h3;
	// Control fields
	localparam int         CTL_AA    = 7;
	localparam int         CTL_EN    = 6;
	localparam int         CTL_STA   = 5;
	localparam int         CTL_STO   = 4;
	localparam int         CTL_SI    = 3;
	localparam int         CTL_MODE  = 0;
	localparam logic [7:0] CTL_WMASK = 8'hF1;
	localparam logic [7:0] CTL_RST   = 8'h00;
	// Count fields
	localparam int         CNT_LB   = 7;
	localparam int         CNT_BC_W = 7;
	localparam logic [7:0] CNT_RST  = 8'h00;
	// Status codes
	localparam logic [7:0] ST_START     = 8'h08;
	localparam logic [7:0] ST_A_ACK     = 8'h18;
	localparam logic [7:0] ST_A_NACK    = 8'h20;
	localparam logic [7:0] ST_D_ACK     = 8'h28;
	localparam logic [7:0] ST_D_NACK    = 8'h30;
	localparam logic [7:0] ST_LOST      = 8'h38;
	localparam logic [7:0] ST_SLA_R     = 8'hA8;
	localparam logic [7:0] ST_LOST_SLA  = 8'hB0;
	localparam logic [7:0] ST_S_ACK     = 8'hB8;
	localparam logic [7:0] ST_S_NACK    = 8'hC0;
	localparam logic [7:0] ST_S_LAST    = 8'hC8;
	localparam logic [7:0] ST_IDLE      = 8'hF8;
	// Host Avalon byte offsets
	localparam int         HA_W      = 5;
	localparam logic [4:0] H_STAT    = 5'h10;
	localparam logic [4:0] H_INIT    = 5'h14;
	localparam logic [4:0] H_RESP    = 5'h18;
	localparam int         HST_IRQ   = 0;
	localparam int         HST_MATCH = 1;
	// States
	typedef enum logic [2:0] {
		M_IDLE = 3'b000, M_START = 3'b001, M_HOLD = 3'b011,
		M_BIT = 3'b010, M_STOP = 3'b110
	} smt_mst_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_ADDR = 3'b001, S_ACK = 3'b011, S_WAIT = 3'b010,
		S_TX = 3'b110, S_RACK = 3'b111, S_DONE = 3'b101
	} smt_slv_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'b00, H_PB = 2'b01, H_CAP = 2'b11, H_DONE = 2'b10
	} smt_hst_t;
endpackage
`default_nettype wire

// *** logic/smt_pbus_if.sv ***
// Purpose: parallel bus between host end and serial engine
// Assumes: one clock, strobes are one-cycle pulses
// Notes:   int_n is active low
`timescale 1ns/100ps
`default_nettype none
interface smt_pbus_if;
	logic [1:0] addr;
	logic       wr;
	logic       rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       int_n;
	modport dev  (input addr, wr, rd, wdata, output rdata, int_n);
	modport host (output addr, wr, rd, wdata, input rdata, int_n);
endinterface
`default_nettype wire

// *** logic/smt_tick.sv ***
// Purpose: quarter-bit enable divider
// Assumes: DIV of at least 2
// Notes:   restarts whenever en_i drops
`timescale 1ns/100ps
`default_nettype none
module smt_tick #(
	parameter int DIV = 4
)(
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic arst_n_i,
	// Control
	input  wire logic en_i,
	// Enable pulse
	output logic      tick_o
);
	localparam int CW = $clog2(DIV + 1);
	logic [CW-1:0] cnt_q;
	wire logic     wrap;
	assign wrap = (cnt_q == CW'(DIV - 1));
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt_q  <= '0;
			tick_o <= 1'b0;
		end
		else
		begin
			cnt_q  <= (!en_i || wrap) ? '0 : cnt_q + 1'b1;
			tick_o <= en_i && wrap;
		end
	end
endmodule
`default_nettype wire

// *** logic/smt_host.sv ***
// Purpose: host end, Avalon-MM slave driving the parallel bus
// Assumes: Avalon byte addresses, 32-bit data
// Notes:   one parallel-bus access in flight at a time
`timescale 1ns/100ps
`default_nettype none
module smt_host
	import smt_pkg::*;
(
	// Clock and reset
	input  wire logic            mclk_i,
	input  wire logic            arst_n_i,
	// Avalon-MM slave
	input  wire logic [HA_W-1:0] avs_address_i,
	input  wire logic            avs_read_i,
	input  wire logic            avs_write_i,
	input  wire logic [31:0]     avs_writedata_i,
	output logic      [31:0]     avs_readdata_o,
	output logic                 avs_waitrequest_o,
	// Parallel bus
	smt_pbus_if.host             pb
);
	smt_hst_t   h_q;
	logic [6:0] dcnt_q, bc_q;

	// Control byte with enable on and flag bit clear
	function automatic logic [7:0] mk_ctl(input logic aa, input logic start_request,
		input logic stop_request, input logic mode);
		logic [7:0] c;
		c           = 8'h00;
		c[CTL_AA]   = aa;
		c[CTL_EN]   = 1'b1;
		c[CTL_STA]  = start_request;
		c[CTL_STO]  = stop_request;
		c[CTL_MODE] = mode;
		return c;
	endfunction

	wire logic       req, dev_hit, init_hit, resp_hit, fwd;
	wire logic [1:0] fwd_addr;
	wire logic [7:0] fwd_data, wd;
	wire logic [31:0] loc_rd;
	assign req      = avs_read_i || avs_write_i;
	assign wd       = avs_writedata_i[7:0];
	assign dev_hit  = !avs_address_i[4];
	assign init_hit = avs_write_i && avs_address_i[4:2] == H_INIT[4:2];
	assign resp_hit = avs_write_i && avs_address_i[4:2] == H_RESP[4:2];
	assign fwd      = dev_hit || init_hit || resp_hit;
	assign fwd_addr = dev_hit ? avs_address_i[3:2] : REG_CONTROL;
	// buffered init; slave reply mode 0, flag 0
	assign fwd_data = init_hit ? mk_ctl(wd[CTL_AA], 1'b0, 1'b0, 1'b1) :
		resp_hit ? mk_ctl(wd[CTL_AA], wd[CTL_STA], 1'b0, 1'b0) :
		(fwd_addr == REG_CONTROL) ?
		mk_ctl(wd[CTL_AA], wd[CTL_STA], wd[CTL_STO], wd[CTL_MODE]) &
		{1'b1, wd[CTL_EN], 6'h3F} : wd;
	assign loc_rd = (avs_read_i && avs_address_i[4:2] == H_STAT[4:2]) ?
		{30'h0, dcnt_q == bc_q, !pb.int_n} : 32'h0;

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			h_q               <= H_IDLE;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0;
			{pb.addr, pb.wr, pb.rd, pb.wdata} <= '0;
			dcnt_q            <= 7'h00;
			bc_q              <= 7'h00;
		end
		else
		begin
			pb.wr <= 1'b0;
			pb.rd <= 1'b0;
			case (h_q)
			H_IDLE:
				if (req && fwd)
				begin
					pb.addr  <= fwd_addr;
					pb.wdata <= fwd_data;
					pb.wr    <= avs_write_i;
					pb.rd    <= avs_read_i;
					h_q      <= H_PB;
					if (avs_write_i && fwd_addr == REG_CONTROL)
						dcnt_q <= 7'h00;
					else if (avs_write_i && fwd_addr == REG_DATA)
						dcnt_q <= dcnt_q + 1'b1;
					// shadow of the byte count field
					if (avs_write_i && fwd_addr == REG_COUNT)
						bc_q <= wd[CNT_BC_W-1:0];
				end
				else if (req)
				begin
					avs_readdata_o    <= loc_rd;
					avs_waitrequest_o <= 1'b0;
					h_q               <= H_DONE;
				end
			H_PB: h_q <= H_CAP;
			H_CAP:
			begin
				avs_readdata_o    <= {24'h0, pb.rdata};
				avs_waitrequest_o <= 1'b0;
				h_q               <= H_DONE;
			end
			default:
			begin
				avs_waitrequest_o <= 1'b1;
				h_q               <= H_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// *** verification/smt_pbus_asserts.sv ***
// Purpose: checks on the parallel bus between host end and engine
// Assumes: one clock domain, active-low asynchronous reset
// Notes:   shadows hold the last count and control written
`timescale 1ns/100ps
`default_nettype none
module smt_pbus_asserts
	import smt_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       arst_n_i,
	// Parallel bus
	input  wire logic [1:0] addr_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       int_n_i
);
	logic [7:0] cnt_q;
	logic [7:0] ctl_q;
	wire        ctl_wr = wr_i && addr_i == REG_CONTROL;
	wire        cnt_wr = wr_i && addr_i == REG_COUNT;
	wire        ctl_rd = rd_i && addr_i == REG_CONTROL;
////////////////////////////////////////
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cnt_q <= CNT_RST;
			ctl_q <= CTL_RST;
		end
		else
		begin
			if (cnt_wr)
				cnt_q <= wdata_i;
			if (ctl_wr)
				ctl_q <= wdata_i;
		end
	end
////////////////////////////////////////
	default clocking dc @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	chk_int_release: assert property (ctl_wr |-> ##[1:2] int_n_i)
		else $error("interrupt not released after control write");
	// Window after a write left open for the release lag
	chk_int_hold: assert property (!int_n_i && !ctl_wr
		&& !$past(ctl_wr) && !$past(ctl_wr, 2) |=> !int_n_i)
		else $error("interrupt released without control write");
	chk_stat_align: assert property (rd_i && addr_i == REG_STATUS
		|=> rdata_i[2:0] == 3'h0)
		else $error("status code not a multiple of eight");
	chk_cnt_readback: assert property (rd_i && addr_i == REG_COUNT
		|=> rdata_i == cnt_q)
		else $error("count readback differs from last write");
	chk_ctl_readback: assert property (ctl_rd |=>
		((rdata_i ^ ctl_q) & 8'hC1) == 8'h00 && rdata_i[2:1] == 2'h0)
		else $error("control readback differs from last write");
	chk_flag_mirror: assert property (ctl_rd && $stable(int_n_i)
		&& $past(int_n_i, 2) == int_n_i
		|=> rdata_i[CTL_SI] == !$past(int_n_i))
		else $error("event flag and interrupt line disagree");
	chk_strobe_pulse: assert property ((wr_i || rd_i)
		|=> !(wr_i || rd_i))
		else $error("strobe longer than one cycle");
	chk_strobe_excl: assert property (!(wr_i && rd_i))
		else $error("read and write strobes together");
	chk_rdata_hold: assert property (!rd_i |=> $stable(rdata_i))
		else $error("read data changed without read");
endmodule
`default_nettype wire

// *** verification/i2c_slave_tx_and_buffered_master_tx_test.sv ***
// Purpose: self-checking bench for host end and serial engine together
// Assumes: 200 MHz clock, short oscillator and bit counts
// Notes:   bench plays serial master and acking slave on the wires
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_tx_and_buffered_master_tx_test
	import smt_pkg::*;
;
	localparam int          Q    = 4;
	localparam logic [4:0]  A_ST = {1'b0, REG_STATUS, 2'b00};
	localparam logic [4:0]  A_DT = {1'b0, REG_DATA, 2'b00};
	localparam logic [4:0]  A_CN = {1'b0, REG_COUNT, 2'b00};
	localparam logic [4:0]  A_CT = {1'b0, REG_CONTROL, 2'b00};
	// Count, byte refused, status, last byte seen on the wire
	localparam logic [31:0] MT [4] = '{32'h8307_28C3, 32'h0107_18A4,
		32'h0300_20A4, 32'h0301_305A};
	localparam logic [7:0]  BY [3] = '{8'hA4, 8'h5A, 8'hC3};
	logic        mclk_i   = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [4:0]  av_a     = 5'h00;
	logic        av_r     = 1'b0;
	logic        av_w     = 1'b0;
	logic [31:0] av_d     = 32'h0;
	logic [31:0] av_q;
	logic        av_wait;
	logic        scl_oe;
	logic        sda_oe;
	logic        m_scl_oe = 1'b0;
	logic        m_sda_oe = 1'b0;
	logic        r_sda_oe = 1'b0;
	logic        r_en     = 1'b0;
	logic [2:0]  nack_at  = 3'h7;
	logic        ps       = 1'b1;
	logic        pd       = 1'b1;
	logic [3:0]  rbit     = 4'h0;
	logic [2:0]  rbyte    = 3'h0;
	logic [7:0]  rsh      = 8'h00;
	logic [7:0]  rlast    = 8'h00;
	int          failures = 0;
	int          compares = 0;
	int          cyc      = 0;
	// Open-drain wires, pulled up when nobody drives
	wire         scl      = !(scl_oe || m_scl_oe);
	wire         sda      = !(sda_oe || m_sda_oe || r_sda_oe);
	smt_pbus_if pb_if ();
	smt_device #(.OSC_CYC(20), .QTR_CYC(Q)) smt_device_inst (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .pb(pb_if),
		.scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe_o(sda_oe));
	smt_host smt_host_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.avs_address_i(av_a), .avs_read_i(av_r), .avs_write_i(av_w),
		.avs_writedata_i(av_d), .avs_readdata_o(av_q),
		.avs_waitrequest_o(av_wait), .pb(pb_if));
	smt_pbus_asserts smt_pbus_asserts_inst (.mclk_i(mclk_i),
		.arst_n_i(arst_n_i), .addr_i(pb_if.addr), .wr_i(pb_if.wr),
		.rd_i(pb_if.rd), .wdata_i(pb_if.wdata), .rdata_i(pb_if.rdata),
		.int_n_i(pb_if.int_n));
	always #2.5 mclk_i = ~mclk_i;
////////////////////////////////////////
	// Acking slave; refuses the byte numbered nack_at
	always @(posedge mclk_i)
	begin
		ps <= scl;
		pd <= sda;
		if (ps && scl && pd && !sda)
		begin
			rbit <= 4'h0;
			rbyte <= 3'h0;
		end
		else if (!ps && scl)
		begin
			rbit <= rbit + 4'h1;
			rsh <= {rsh[6:0], sda};
		end
		else if (ps && !scl && rbit == 4'h8)
		begin
			rlast <= rsh;
			r_sda_oe <= r_en && rbyte != nack_at;
		end
		else if (ps && !scl && rbit == 4'h9)
		begin
			r_sda_oe <= 1'b0;
			rbit <= 4'h0;
			rbyte <= rbyte + 3'h1;
		end
	end
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			failures = failures + 1;
			finish_test();
		end
	end
////////////////////////////////////////
	task finish_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is sampled low
	task av(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge mclk_i);
		av_a <= a;
		av_w <= w;
		av_r <= !w;
		av_d <= {24'h0, d};
		do @(posedge mclk_i); while (av_wait !== 1'b0);
		q = av_q[7:0];
		av_w <= 1'b0;
		av_r <= 1'b0;
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] x;
		av(1'b1, a, d, x);
	endtask
	task rdc(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] x;
		av(1'b0, a, 8'h00, x);
		chk(x, e);
	endtask
	task st(input logic [7:0] e);
		@(posedge mclk_i);
		while (pb_if.int_n !== 1'b0)
			@(posedge mclk_i);
		rdc(A_ST, e);
		rdc(A_ST, e);
	endtask
	task qt(input int n);
		repeat (n * Q) @(posedge mclk_i);
	endtask
	task m_bit(input logic b, output logic r);
		m_sda_oe <= !b;
		qt(1);
		m_scl_oe <= 1'b0;
		do @(posedge mclk_i); while (scl !== 1'b1);
		qt(1);
		r = sda;
		qt(1);
		m_scl_oe <= 1'b1;
		qt(1);
	endtask
	task m_byte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			m_bit(b[i], r[i]);
	endtask
	task m_stop;
		m_sda_oe <= 1'b1;
		qt(1);
		m_scl_oe <= 1'b0;
		qt(2);
		m_sda_oe <= 1'b0;
		qt(2);
	endtask
	task m_addr(input logic e);
		logic [7:0] x;
		logic       a;
		m_sda_oe <= 1'b1;
		qt(2);
		m_scl_oe <= 1'b1;
		qt(1);
		m_byte({OWN_ADDR_DEF, 1'b1}, x);
		m_bit(1'b1, a);
		chk({7'h00, a}, {7'h00, e});
	endtask
	// Zero status means the byte raises no event
	task s_rd(input logic [7:0] e, input logic mack, input logic [7:0] es);
		logic [7:0] x;
		logic       a;
		m_byte(8'hFF, x);
		chk(x, e);
		m_bit(mack, a);
		if (es !== 8'h00)
			st(es);
	endtask
////////////////////////////////////////
	task t_regs;
		rdc(A_ST, ST_IDLE);
		rdc(A_CT, CTL_RST);
		rdc(5'h1C, 8'h00);
		wr(A_CN, 8'hC5);
		rdc(A_CN, 8'hC5);
		wr(A_ST, 8'h55);
		rdc(A_ST, ST_IDLE);
	endtask
	task t_slave;
		wr(A_CT, 8'hC0);
		repeat (40) @(posedge mclk_i);
		m_addr(1'b0);
		st(ST_SLA_R);
		wr(A_DT, 8'hA5);
		wr(A_CT, 8'hC0);
		s_rd(8'hA5, 1'b0, ST_S_ACK);
		wr(A_DT, 8'h3C);
		wr(A_CT, 8'h40);
		s_rd(8'h3C, 1'b0, ST_S_LAST);
		wr(A_CT, 8'h40);
		s_rd(8'hFF, 1'b1, 8'h00);
		m_stop();
		m_addr(1'b1);
		m_stop();
		wr(A_CT, 8'hC0);
		m_addr(1'b0);
		st(ST_SLA_R);
		wr(A_DT, 8'h81);
		wr(H_RESP, 8'h80);
		s_rd(8'h81, 1'b1, ST_S_NACK);
		wr(A_CT, 8'hC0);
		m_stop();
		m_addr(1'b0);
		st(ST_SLA_R);
		wr(A_DT, 8'h7E);
		wr(A_CT, 8'h40);
		s_rd(8'h7E, 1'b1, ST_S_NACK);
		wr(A_CT, 8'h60);
		m_stop();
		st(ST_START);
		wr(A_CT, 8'h50);
	endtask
	task t_master;
		logic [7:0] x;
		r_en <= 1'b1;
		wr(H_INIT, 8'h40);
		for (int i = 0; i < 4; i++)
		begin
			nack_at <= MT[i][18:16];
			wr(A_CN, MT[i][31:24]);
			wr(A_CT, 8'h61);
			st(ST_START);
			for (int j = 0; j < int'(MT[i][30:24]); j++)
				wr(A_DT, BY[j]);
			rdc(H_STAT, 8'h03);
			wr(A_CT, 8'h41);
			st(MT[i][15:8]);
			chk(rlast, MT[i][7:0]);
			wr(A_CT, 8'h51);
			do av(1'b0, A_CT, 8'h00, x); while (x[CTL_STO] !== 1'b0);
		end
	endtask
	initial
	begin
		repeat (12) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		t_regs();
		t_slave();
		t_master();
		finish_test();
	end
endmodule
`default_nettype wire
